// ---- core/dcts_addr_if.sv ----
// carrier between the sequencer and one address stepper
// assumes dcts_pkg is compiled first
`timescale 1ns/10ps

interface dcts_addr_if;
  import dcts_pkg::*;
  logic [AW-1:0] addr;
  logic [AW-1:0] next;
  dcts_amode_t mode;
  logic byte_mode;
  modport calc(input addr, input mode, input byte_mode, output next);
  modport user(output addr, output mode, output byte_mode, input next);
endinterface

// ---- core/dcts_addr_step.sv ----
// next-address calculator for a source or destination pointer
// assumes the pointer register is held by the instantiating module
`timescale 1ns/10ps

module dcts_addr_step (
  dcts_addr_if.calc a
);
  import dcts_pkg::*;

  // ---------------------------------------------------------------
  // step by mode and size
  // ---------------------------------------------------------------
  logic [AW-1:0] step;

  always_comb begin
    step = a.byte_mode ? STEP_BYTE : STEP_WORD;
    unique case (a.mode)
      AM_INC: a.next = a.addr + step;
      AM_DEC: a.next = a.addr - step;
      AM_FIXED: a.next = a.addr;
      AM_PIA: a.next = a.addr;
    endcase
    // word transfers never leave the even byte lane
    if (!a.byte_mode) begin
      a.next[0] = 1'b0;
    end
  end

endmodule

// ---- core/dcts_limit_chk.sv ----
// shared upper and lower address-limit comparator
// assumes both addresses are the ones just accessed, not the next ones
`timescale 1ns/10ps

module dcts_limit_chk (
  input wire logic [dcts_pkg::AW-1:0] src_addr,
  input wire logic [dcts_pkg::AW-1:0] dst_addr,
  input wire logic [dcts_pkg::AW-1:0] upper,
  input wire logic [dcts_pkg::AW-1:0] lower,
  output logic high_hit,
  output logic low_hit
);
  import dcts_pkg::*;

  logic [AW-1:0] acc [2];
  logic [1:0] hi;
  logic [1:0] lo;

  assign acc[0] = src_addr;
  assign acc[1] = dst_addr;

  for (genvar i = 0; i < 2; i++) begin : g_chk
    assign hi[i] = acc[i] > upper;
    // the sfr region below the lower limit stays reachable
    assign lo[i] = (acc[i] < lower) && (acc[i] >= SFR_END);
  end

  assign high_hit = |hi;
  assign low_hit = |lo;

endmodule

// ---- core/dcts_pkg.sv ----
// constants and types shared by the transfer sequencer and its helpers
// assumes a 16-bit data space and a 32-bit apb register window

package dcts_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int PAW = 8;
  localparam int PDW = 32;
  localparam int SEL_W = 6;
  localparam int TRIG_COUNT = 64;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [PAW-1:0] OFS_CTRL = 8'h00;
  localparam logic [PAW-1:0] OFS_INT = 8'h04;
  localparam logic [PAW-1:0] OFS_SRC = 8'h08;
  localparam logic [PAW-1:0] OFS_DST = 8'h0C;
  localparam logic [PAW-1:0] OFS_CNT = 8'h10;
  localparam logic [PAW-1:0] OFS_UPPER = 8'h14;
  localparam logic [PAW-1:0] OFS_LOWER = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_EN = 0;
  localparam int B_SIZE = 1;
  localparam int B_MODE_LO = 2;
  localparam int B_DAM_LO = 4;
  localparam int B_SAM_LO = 6;
  localparam int B_REQ = 8;
  localparam int B_RELOAD = 9;
  localparam int B_NULL_WRITE_MODE = 10;
  localparam int B_OVRUNIF = 3;
  localparam int B_DONEIF = 5;
  localparam int B_LOWIF = 6;
  localparam int B_HIGHIF = 7;
  localparam int B_SEL_LO = 8;
  localparam int B_BUFWF = 15;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] SFR_END = 16'h0800;
  localparam logic [AW-1:0] CNT_RST = 16'h0001;
  localparam logic [AW-1:0] CNT_STEP = 16'h0001;
  localparam logic [AW-1:0] STEP_BYTE = 16'h0001;
  localparam logic [AW-1:0] STEP_WORD = 16'h0002;
  localparam logic [AW-1:0] LIMIT_RST = 16'h0000;

  typedef enum logic [1:0] {
    TM_ONESHOT = 2'h0,
    TM_REP_ONESHOT = 2'h1,
    TM_CONT = 2'h2,
    TM_REP_CONT = 2'h3
  } dcts_tmode_t;

  typedef enum logic [1:0] {
    AM_FIXED = 2'h0,
    AM_INC = 2'h1,
    AM_DEC = 2'h2,
    AM_PIA = 2'h3
  } dcts_amode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_NULL_WRITE_MODE,
    ST_UPDATE
  } dcts_state_t;

endpackage

// ---- core/dcts_sequencer.sv ----
// one dma channel: trigger select, buffered read/write, count and limits
// assumes an apb master for registers and a req/ack data-space port
`timescale 1ns/10ps

module dcts_sequencer #(
  parameter int N_TRIG = dcts_pkg::TRIG_COUNT
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dcts_pkg::PAW-1:0] PADDR,
  input wire logic [dcts_pkg::PDW-1:0] PWDATA,
  output logic [dcts_pkg::PDW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N_TRIG-1:0] TRIGGERS,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_BYTE,
  output logic [dcts_pkg::AW-1:0] MEM_ADDR,
  output logic [dcts_pkg::DW-1:0] MEM_WDATA,
  input wire logic [dcts_pkg::DW-1:0] MEM_RDATA,
  input wire logic MEM_ACK
);
  import dcts_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic en_reg;
  logic size_reg;
  dcts_tmode_t mode_reg;
  dcts_amode_t sam_reg;
  dcts_amode_t dam_reg;
  logic req_reg;
  logic reload_reg;
  logic null_write_mode_reg;
  logic [SEL_W-1:0] sel_reg;
  logic highif_reg;
  logic lowif_reg;
  logic doneif_reg;
  logic ovrun_reg;
  logic [AW-1:0] src_reg;
  logic [AW-1:0] dst_reg;
  logic [AW-1:0] cnt_reg;
  logic [AW-1:0] src_save_reg;
  logic [AW-1:0] dst_save_reg;
  logic [AW-1:0] cnt_save_reg;
  logic restore_reg;
  logic [AW-1:0] upper_reg;
  logic [AW-1:0] lower_reg;
  dcts_state_t state_reg;
  logic [DW-1:0] buf_reg;
  logic bufwf_reg;
  logic trig_d_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [PDW-1:0] prdata_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic mem_byte_reg;
  logic [AW-1:0] mem_addr_reg;
  logic [DW-1:0] mem_wdata_reg;

  logic apb_take;
  logic apb_wr;
  logic [PDW-1:0] rd_word;
  logic rd_err;
  logic trig_sel;
  logic hw_trig;
  logic busy;
  logic start;
  logic upd;
  logic [AW-1:0] cnt_dec;
  logic cnt_zero;
  logic repeated;
  logic continuous;
  logic high_hit;
  logic low_hit;
  logic violate;
  logic stop_en;
  logic wrap;
  logic again;
  logic [AW-1:0] rd_addr;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // ---------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ---------------------------------------------------------------
  assign apb_take = PSEL && PENABLE && !pready_reg;
  assign apb_wr = PSEL && PENABLE && pready_reg && PWRITE;

  always_comb begin
    rd_word = '0;
    rd_err = 1'b0;
    unique case (PADDR)
      OFS_CTRL: begin
        rd_word[B_EN] = en_reg;
        rd_word[B_SIZE] = size_reg;
        rd_word[B_MODE_LO +: 2] = mode_reg;
        rd_word[B_DAM_LO +: 2] = dam_reg;
        rd_word[B_SAM_LO +: 2] = sam_reg;
        rd_word[B_REQ] = req_reg;
        rd_word[B_RELOAD] = reload_reg;
        rd_word[B_NULL_WRITE_MODE] = null_write_mode_reg;
      end
      OFS_INT: begin
        rd_word[B_BUFWF] = bufwf_reg;
        rd_word[B_SEL_LO +: SEL_W] = sel_reg;
        rd_word[B_HIGHIF] = highif_reg;
        rd_word[B_LOWIF] = lowif_reg;
        rd_word[B_DONEIF] = doneif_reg;
        rd_word[B_OVRUNIF] = ovrun_reg;
      end
      OFS_SRC: rd_word[AW-1:0] = src_reg;
      OFS_DST: rd_word[AW-1:0] = dst_reg;
      OFS_CNT: rd_word[AW-1:0] = cnt_reg;
      OFS_UPPER: rd_word[AW-1:0] = upper_reg;
      OFS_LOWER: rd_word[AW-1:0] = lower_reg;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= apb_take;
      pslverr_reg <= apb_take && rd_err;
      prdata_reg <= (apb_take && !PWRITE) ? rd_word : '0;
    end
  end

  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;

  // ---------------------------------------------------------------
  // trigger and sequencing decisions
  // ---------------------------------------------------------------
  // the select only picks a line; addresses play no part in it
  assign trig_sel = TRIGGERS[sel_reg];
  assign hw_trig = trig_sel && !trig_d_reg;
  assign busy = state_reg != ST_IDLE;
  assign rd_addr = restore_reg ? src_save_reg : src_reg;
  assign start = (state_reg == ST_IDLE) && en_reg && req_reg;
  assign upd = state_reg == ST_UPDATE;
  assign cnt_dec = cnt_reg - CNT_STEP;
  assign cnt_zero = cnt_dec == '0;
  assign repeated = (mode_reg == TM_REP_ONESHOT) || (mode_reg == TM_REP_CONT);
  assign continuous = (mode_reg == TM_CONT) || (mode_reg == TM_REP_CONT);
  assign violate = high_hit || low_hit;
  assign stop_en = upd && ((cnt_zero && !repeated) || (!cnt_zero && violate));
  assign wrap = upd && cnt_zero && repeated;
  // a burst keeps going only while nothing stopped it
  assign again = upd && continuous && !cnt_zero && !violate && en_reg;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_sel;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      en_reg <= 1'b0;
      size_reg <= 1'b0;
      mode_reg <= TM_ONESHOT;
      sam_reg <= AM_FIXED;
      dam_reg <= AM_FIXED;
      reload_reg <= 1'b0;
      null_write_mode_reg <= 1'b0;
    end else if (apb_wr && PADDR == OFS_CTRL) begin
      en_reg <= stop_en ? 1'b0 : PWDATA[B_EN];
      size_reg <= PWDATA[B_SIZE];
      mode_reg <= dcts_tmode_t'(PWDATA[B_MODE_LO +: 2]);
      dam_reg <= dcts_amode_t'(PWDATA[B_DAM_LO +: 2]);
      sam_reg <= dcts_amode_t'(PWDATA[B_SAM_LO +: 2]);
      reload_reg <= PWDATA[B_RELOAD];
      null_write_mode_reg <= PWDATA[B_NULL_WRITE_MODE];
    end else if (stop_en) begin
      en_reg <= 1'b0;
    end
  end

  // request: a set from either source beats the end-of-burst clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_reg <= 1'b0;
    end else if (hw_trig || (apb_wr && PADDR == OFS_CTRL && PWDATA[B_REQ])) begin
      req_reg <= 1'b1;
    end else if (upd && !again) begin
      req_reg <= 1'b0;
    end else if (apb_wr && PADDR == OFS_CTRL) begin
      req_reg <= PWDATA[B_REQ];
    end
  end

  AST_TRIG_SETS_REQ: assert property (hw_trig |=> req_reg)
    else $error("selected trigger edge did not set the request");

  AST_START_READS: assert property (start |=> (state_reg == ST_READ && MEM_REQ
      && !MEM_WE && MEM_ADDR == $past(rd_addr)))
    else $error("pending request did not start a source read");

  // ---------------------------------------------------------------
  // select and flags; hardware sets win over software writes
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sel_reg <= '0;
    end else if (apb_wr && PADDR == OFS_INT) begin
      sel_reg <= PWDATA[B_SEL_LO +: SEL_W];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      highif_reg <= 1'b0;
      lowif_reg <= 1'b0;
      doneif_reg <= 1'b0;
      ovrun_reg <= 1'b0;
    end else begin
      if (upd && high_hit) begin
        highif_reg <= 1'b1;
      end else if (apb_wr && PADDR == OFS_INT) begin
        highif_reg <= PWDATA[B_HIGHIF];
      end
      if (upd && low_hit) begin
        lowif_reg <= 1'b1;
      end else if (apb_wr && PADDR == OFS_INT) begin
        lowif_reg <= PWDATA[B_LOWIF];
      end
      if (upd && cnt_zero) begin
        doneif_reg <= 1'b1;
      end else if (apb_wr && PADDR == OFS_INT) begin
        doneif_reg <= PWDATA[B_DONEIF];
      end
      if (hw_trig && busy) begin
        ovrun_reg <= 1'b1;
      end else if (apb_wr && PADDR == OFS_INT) begin
        ovrun_reg <= PWDATA[B_OVRUNIF];
      end
    end
  end

  AST_HIGH_FLAG: assert property ((upd && high_hit) |=> highif_reg)
    else $error("upper limit crossing did not raise its flag");

  AST_LOW_FLAG: assert property ((upd && low_hit) |=> lowif_reg)
    else $error("lower limit crossing did not raise its flag");

  // ---------------------------------------------------------------
  // addresses, count, saved copies and limits
  // ---------------------------------------------------------------
  dcts_addr_if src_if ();
  dcts_addr_if dst_if ();

  assign src_if.addr = src_reg;
  assign src_if.mode = sam_reg;
  assign src_if.byte_mode = size_reg;
  assign dst_if.addr = dst_reg;
  assign dst_if.mode = dam_reg;
  assign dst_if.byte_mode = size_reg;

  dcts_addr_step u_src_step (
    .a(src_if)
  );

  dcts_addr_step u_dst_step (
    .a(dst_if)
  );

  // one limit pair, shared by every access of the channel
  dcts_limit_chk u_limit (
    .src_addr(src_reg),
    .dst_addr(dst_reg),
    .upper(upper_reg),
    .lower(lower_reg),
    .high_hit(high_hit),
    .low_hit(low_hit)
  );

  always_ff @(posedge CLK) begin
    if (RESET) begin
      upper_reg <= LIMIT_RST;
      lower_reg <= LIMIT_RST;
    end else if (apb_wr && PADDR == OFS_UPPER) begin
      upper_reg <= PWDATA[AW-1:0];
    end else if (apb_wr && PADDR == OFS_LOWER) begin
      lower_reg <= PWDATA[AW-1:0];
    end
  end

  // hardware updates take the cycle; a register write in that cycle is lost
  always_ff @(posedge CLK) begin
    if (RESET) begin
      src_reg <= '0;
      dst_reg <= '0;
      cnt_reg <= CNT_RST;
      src_save_reg <= '0;
      dst_save_reg <= '0;
      cnt_save_reg <= CNT_RST;
      restore_reg <= 1'b0;
    end else if (start && restore_reg) begin
      src_reg <= src_save_reg;
      dst_reg <= dst_save_reg;
      cnt_reg <= cnt_save_reg;
      restore_reg <= 1'b0;
    end else if (wrap) begin
      src_reg <= src_save_reg;
      dst_reg <= dst_save_reg;
      cnt_reg <= cnt_save_reg;
    end else if (upd) begin
      src_reg <= src_if.next;
      dst_reg <= dst_if.next;
      cnt_reg <= cnt_dec;
      restore_reg <= cnt_zero && reload_reg;
    end else if (apb_wr && PADDR == OFS_SRC) begin
      src_reg <= PWDATA[AW-1:0];
      src_save_reg <= PWDATA[AW-1:0];
    end else if (apb_wr && PADDR == OFS_DST) begin
      dst_reg <= PWDATA[AW-1:0];
      dst_save_reg <= PWDATA[AW-1:0];
    end else if (apb_wr && PADDR == OFS_CNT) begin
      cnt_reg <= PWDATA[AW-1:0];
      cnt_save_reg <= PWDATA[AW-1:0];
    end
  end

  AST_COUNT_DEC: assert property ((upd && !wrap) |=>
      cnt_reg == $past(cnt_reg) - CNT_STEP)
    else $error("count did not drop by one after a transfer");

  AST_REPEAT_RELOAD: assert property (wrap |=> (cnt_reg == $past(cnt_save_reg)
      && src_reg == $past(src_save_reg) && dst_reg == $past(dst_save_reg)))
    else $error("repeated mode did not reload at zero");

  AST_ZERO_DISABLE: assert property ((upd && cnt_zero && !repeated) |=>
      (!en_reg && state_reg == ST_IDLE))
    else $error("channel still enabled after count reached zero");

  AST_LIMIT_TERM: assert property ((upd && !cnt_zero && violate) |=>
      (!en_reg && state_reg == ST_IDLE))
    else $error("limit crossing did not terminate the channel");

  // ---------------------------------------------------------------
  // transfer engine on the data-space port
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      buf_reg <= '0;
      bufwf_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_byte_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_READ;
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_byte_reg <= size_reg;
            mem_addr_reg <= rd_addr;
          end
        end
        ST_READ: begin
          if (MEM_ACK) begin
            state_reg <= ST_WRITE;
            buf_reg <= MEM_RDATA;
            bufwf_reg <= 1'b1;
            mem_we_reg <= 1'b1;
            mem_addr_reg <= dst_reg;
            mem_wdata_reg <= MEM_RDATA;
          end
        end
        ST_WRITE: begin
          if (MEM_ACK && null_write_mode_reg) begin
            state_reg <= ST_NULL_WRITE_MODE;
            mem_addr_reg <= src_reg;
            mem_wdata_reg <= buf_reg;
          end else if (MEM_ACK) begin
            state_reg <= ST_UPDATE;
            bufwf_reg <= 1'b0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
          end
        end
        ST_NULL_WRITE_MODE: begin
          if (MEM_ACK) begin
            state_reg <= ST_UPDATE;
            bufwf_reg <= 1'b0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
          end
        end
        ST_UPDATE: begin
          // continuous modes go straight back to the source read unless the count ends, a limit is hit or the channel is off
          if (again) begin
            state_reg <= ST_READ;
            mem_req_reg <= 1'b1;
            mem_byte_reg <= size_reg;
            mem_addr_reg <= src_if.next;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign MEM_REQ = mem_req_reg;
  assign MEM_WE = mem_we_reg;
  assign MEM_BYTE = mem_byte_reg;
  assign MEM_ADDR = mem_addr_reg;
  assign MEM_WDATA = mem_wdata_reg;

  AST_READ_THEN_WRITE: assert property ((state_reg == ST_READ && MEM_ACK) |=>
      (MEM_REQ && MEM_WE && bufwf_reg && MEM_WDATA == $past(MEM_RDATA)
      && MEM_ADDR == $past(dst_reg)))
    else $error("read data not forwarded to the destination write");

  AST_BUFWF_CLEAR: assert property ((state_reg == ST_WRITE && MEM_ACK
      && !null_write_mode_reg) |=> (!bufwf_reg && !MEM_REQ))
    else $error("pending-write flag not cleared after the store");

  AST_CONT_AGAIN: assert property (again |=> (state_reg == ST_READ
      && MEM_ADDR == src_reg))
    else $error("continuous mode did not start the next transfer");

  AST_ONESHOT_WAIT: assert property ((upd && !continuous) |=>
      (state_reg == ST_IDLE && !MEM_REQ))
    else $error("one-shot mode ran more than one transfer");

endmodule

// ---- testbench/dcts_ram_model.sv ----
// data-space memory behind the sequencer's req/ack port
// assumes one access at a time; ack is a one-cycle pulse
`timescale 1ns/10ps

module dcts_ram_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [0:32767];
  logic [1:0] wait_reg;
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'hC3C3;
  // ---------------------------------------------------------------
  // answer
  // ---------------------------------------------------------------
  // read data flips whenever no answer stands, so stale data never looks valid
  always @(posedge clk) begin
    rdata <= ~rdata;
    if (reset) begin
      ack <= 1'b0;
      wait_reg <= 2'h0;
      rdata <= 16'h5A5A;
    end else if (ack) begin
      ack <= 1'b0;
      wait_reg <= slow ? addr[2:1] + 2'h1 : 2'h0;
    end else if (req && wait_reg == 2'h0) begin
      ack <= 1'b1;
      if (we) mem[addr[15:1]] <= wdata;
      else rdata <= mem[addr[15:1]];
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule

// ---- testbench/tb_dma_channel_transfer_sequencer.sv ----
// self-checking bench for one dma channel sequencer
// assumes dcts_pkg, the design files and dcts_ram_model are compiled first
`timescale 1ns/10ps

module tb_dma_channel_transfer_sequencer;
  import dcts_pkg::*;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
  logic [PAW-1:0] PADDR = 8'h00;
  logic [PDW-1:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, MEM_REQ, MEM_WE, MEM_BYTE, MEM_ACK, err, sz;
  logic [TRIG_COUNT-1:0] TRIGGERS = 64'h0;
  logic [AW-1:0] MEM_ADDR, s, d, ls, ld, ctl;
  logic [DW-1:0] MEM_WDATA, MEM_RDATA;
  logic [5:0] sel;
  logic [1:0] sam, dam;
  int bad_count = 0, checks_done = 0, seed = 29635, tr;

  dcts_sequencer dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TRIGGERS(TRIGGERS), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_BYTE(MEM_BYTE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
  dcts_ram_model ram (.clk(CLK), .reset(RESET), .slow(slow), .req(MEM_REQ), .we(MEM_WE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ack(MEM_ACK));
  initial forever #10 CLK = ~CLK;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one edge passes after release so no strobe is assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] v);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0, v};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 16'h0);
    check(rd, want);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 16'h0);
      n++;
    end while (rd[B_REQ] !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic lim(input logic [15:0] up, input logic [15:0] lo, input logic [15:0] a,
                     input logic [31:0] cnt, input logic [31:0] flags);
    wr(OFS_UPPER, up);
    wr(OFS_LOWER, lo);
    wr(OFS_INT, 16'h0);
    wr(OFS_SRC, a);
    wr(OFS_DST, 16'h1800);
    wr(OFS_CNT, 16'h4);
    wr(OFS_CTRL, 16'h0149);
    wait_idle();
    rchk(OFS_CNT, cnt);
    rchk(OFS_CTRL, 32'h48);
    rchk(OFS_INT, flags);
  endtask
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {1'b0, a[15:1]} ^ 16'hC3C3;
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] a, input logic [1:0] m, input logic b);
    logic [15:0] st;
    st = b ? STEP_BYTE : STEP_WORD;
    return m == 2'h1 ? a + st : m == 2'h2 ? a - st : a;
  endfunction

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    rchk(OFS_CNT, 32'h1);
    rchk(OFS_CTRL, 32'h0);
    apb(1'b0, 8'h1C, 16'h0);
    check({31'h0, err}, 32'h1);
    wr(OFS_INT, 16'h8000);
    rchk(OFS_INT, 32'h0);
    wr(OFS_UPPER, 16'hFFFF);
    wr(OFS_LOWER, SFR_END);
    for (int m = 0; m < 4; m++) begin
      sel = 6'($random(seed));
      s = {4'h1, 11'($random(seed)), 1'b0};
      d = {4'h4, 11'($random(seed)), 1'b0};
      {sam, dam, sz} = 5'($random(seed));
      // corner: word with null write on even passes, byte on odd ones
      sz = m[0];
      slow <= m[0];
      wr(OFS_INT, {2'h0, sel, 8'h0});
      wr(OFS_SRC, s);
      wr(OFS_DST, d);
      wr(OFS_CNT, 16'h2);
      ctl = {5'h0, ~sz, 2'h0, sam, dam, 2'(m), sz, 1'b1};
      wr(OFS_CTRL, ctl | {7'h0, ~m[0], 8'h0});
      if (m[0]) begin
        // other lines rise first; only the selected one may start a transfer
        TRIGGERS <= {$random(seed), $random(seed)} & ~(64'h1 << sel);
        @(posedge CLK);
        TRIGGERS <= 64'h1 << sel;
        @(posedge CLK);
        TRIGGERS <= 64'h0;
        apb(1'b0, OFS_CTRL, 16'h0);
        check({31'h0, rd[B_REQ]}, 32'h1);
      end
      wait_idle();
      check({31'h0, MEM_BYTE}, {31'h0, sz});
      tr = m[1] ? 2 : 1;
      ls = s;
      ld = d;
      if (tr == 2) begin
        ls = nxt(s, sam, sz);
        ld = nxt(d, dam, sz);
      end
      if (!sz) check({16'h0, ram.mem[ld[15:1]]}, {16'h0, pat(ls)});
      rchk(OFS_SRC, {16'h0, m == 3 ? s : nxt(ls, sam, sz)});
      rchk(OFS_DST, {16'h0, m == 3 ? d : nxt(ld, dam, sz)});
      rchk(OFS_CNT, m == 3 ? 32'h2 : 32'(2 - tr));
      rchk(OFS_CTRL, {16'h0, ctl & {15'h7FFF, m != 2}});
      rchk(OFS_INT, {16'h0, 2'h0, sel, 2'h0, m[1], 5'h0});
      $display("end of mode test %0d", m);
    end
    lim(16'h2002, SFR_END, 16'h2000, 32'h1, 32'h80);
    lim(16'hFFFF, 16'h1000, 16'h07FE, 32'h2, 32'h40);
    lim(16'hFFFF, 16'h1000, 16'h0400, 32'h0, 32'h20);
    $display("end of limit tests");
    // reload: a re-enabled one-shot restarts from the saved copies;
    // the trigger pulse lands while busy and must raise overrun
    wr(OFS_INT, 16'h0);
    wr(OFS_SRC, 16'h3000);
    wr(OFS_DST, 16'h5000);
    wr(OFS_CNT, 16'h1);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 16'h0351);
      TRIGGERS <= 64'h1;
      @(posedge CLK);
      TRIGGERS <= 64'h0;
      wait_idle();
    end
    rchk(OFS_SRC, 32'h3002);
    rchk(OFS_DST, 32'h5002);
    rchk(OFS_CNT, 32'h0);
    rchk(OFS_INT, 32'h28);
    check({16'h0, ram.mem[16'h2800]}, {16'h0, pat(16'h3000)});
    $display("end of reload test");
    close_out();
  end
endmodule
